// ==== verilog/est_pkg.sv ====
// Constants shared by the eight/sixteen-bit timer counter.
// Assumes a 40 MHz core clock. All device resets arrive merged on one reset.
package est_pkg;
	// ------------------------------------------------------------
	// Register byte offsets (Avalon-MM, one word per register)
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL_A   = 5'h00;
	localparam logic [4:0] OFS_CTRL_B   = 5'h04;
	localparam logic [4:0] OFS_CNT_LOW  = 5'h08;
	localparam logic [4:0] OFS_CNT_HIGH = 5'h0C;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int A_ENABLE_BIT = 7;  // Control A: run enable
	localparam int A_OUT_BIT    = 5;  // Control A: match output state, read only
	localparam int A_WIDTH_BIT  = 4;  // Control A: width_select_bit, 1 = 16-bit
	localparam int B_CNTR_BIT   = 5;  // Control B: 1 = count input pin, 0 = timer
	localparam int B_ASYNC_BIT  = 4;  // Control B: async_select_bit
	localparam int STAT_FLAG    = 0;  // Status/mask: match or overflow event

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_A_RST   = 8'h00;
	localparam logic [7:0] CTRL_B_RST   = 8'h00;
	localparam logic [7:0] CNT_LOW_RST  = 8'h00;
	localparam logic [7:0] CNT_HIGH_RST = 8'hFF;
	localparam logic [7:0] PERIOD_RST   = 8'hFF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         CORE_CLK_HZ   = 40000000;
	localparam int         INST_CLK_HZ   = CORE_CLK_HZ / 4;  // Fosc/4
	localparam int         INST_DIV      = CORE_CLK_HZ / INST_CLK_HZ;
	localparam logic [1:0] INST_DIV_LAST = 2'(INST_DIV - 1);
	localparam int         PRE_WIDTH     = 15;
	localparam logic [3:0] PRE_BYPASS    = 4'h0;
endpackage

// ==== verilog/est_timer.sv ====
// Eight/sixteen-bit timer counter with prescaler, postscaler and an
// Avalon-MM register slave. Assumes one 40 MHz clock, a synchronous reset
// that stands for every device reset, and an asynchronous count input pin.

// Functional notes
// RQ1 - One control bit chooses between 8-bit and 16-bit count width.
// RQ2 - The count advances on rising edges of the chosen source after a 15-bit prescaler set by a 4-bit field.
// RQ3 - In 16-bit width a read of the low byte copies the hidden upper byte into the high buffer.
// RQ4 - In 16-bit width a write of the low byte loads the hidden upper byte from the high buffer.
// RQ5 - In 8-bit width the low byte is compared with the period buffer and cleared when they are equal.
// RQ6 - A period match raises the match output for one prescaled period and reloads the period buffer.
// RQ7 - In 8-bit width both bytes are read/write, and reset clears low and sets high to all ones.
// RQ8 - Prescaler and postscaler clear on a low-byte write, a control write or any reset.
// RQ9 - In counter operation a zero prescale bypasses the prescaler and each rising edge adds one.
// RQ10 - In timer operation a zero prescale counts once per instruction cycle, more slowly otherwise.
// RQ11 - With async select set the count follows source edges without alignment and runs in sleep; the code runs in sleep in counter operation only.
// RQ12 - With async select clear the count is aligned to the instruction clock at a quarter of the core.
// RQ13 - In synchronous operation the input must not toggle faster than the instruction clock.
// RQ14 - The interrupt flag rises on period match or overflow after the postscaler.
// RQ15 - The prescaler belongs to this counter alone and shares nothing with the watchdog.
// RQ16 - The match pulse goes both to on-chip peripherals and to the pin routing logic.
// RQ17 - In 16-bit width the count wraps from all ones to zero and that wrap clocks the postscaler.
module est_timer (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_srst,
	// Avalon-MM slave
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Count source and power state
	input  wire logic        i_count_in,
	input  wire logic        i_sleep,
	// Match pulse and interrupt
	output logic             o_match_periph,
	output logic             o_match_pin,
	output logic             o_irq
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]  ctrl_a_q;
	logic [7:0]  ctrl_b_q;
	logic [7:0]  low_q;
	logic [7:0]  high_true_q;
	logic [7:0]  buf_q;
	logic [7:0]  period_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [1:0]  div_q;
	logic        s1_q;
	logic        s2_q;
	logic        s3_q;
	logic        filt_q;
	logic        filt_prev_q;
	logic [14:0] pre_q;
	logic [3:0]  post_q;
	logic        pend_q;
	logic        out_q;
	logic        stat_q;
	logic        mask_q;
	logic        irq_q;
	logic        rd_go;
	logic        wr_go;
	logic        wr_low;
	logic        wr_high;
	logic        wr_ctrl;
	logic        run;
	logic        w16;
	logic        is_async;
	logic        inst_tick;
	logic        pin_rise;
	logic        raw_evt;
	logic [14:0] pre_mask;
	logic        pre_out;
	logic        cnt_evt;
	logic        match8;
	logic        wrap16;
	logic        evt;
	logic        post_hit;
	logic        scl_clr;
	logic [7:0]  rd_byte;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// One wait state: a read is accepted while waitrequest is high, its data
	// is latched then and it completes at the next edge; a write lands at the completing edge
	assign rd_go   = i_avs_read & wait_q;
	assign wr_go   = i_avs_write & ~wait_q & i_avs_byteenable[0];
	assign wr_low  = wr_go & (i_avs_address == est_pkg::OFS_CNT_LOW);
	assign wr_high = wr_go & (i_avs_address == est_pkg::OFS_CNT_HIGH);
	assign wr_ctrl = wr_go & ((i_avs_address == est_pkg::OFS_CTRL_A) |
	                          (i_avs_address == est_pkg::OFS_CTRL_B));

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			wait_q <= 1'b1;
		end else if (wait_q) begin
			wait_q <= ~(i_avs_read | i_avs_write);
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		rd_byte = 8'h00;
		case (i_avs_address)
			est_pkg::OFS_CTRL_A: begin
				rd_byte = ctrl_a_q;
				rd_byte[est_pkg::A_OUT_BIT] = out_q;
			end
			est_pkg::OFS_CTRL_B:   rd_byte = ctrl_b_q;
			est_pkg::OFS_CNT_LOW:  rd_byte = low_q;
			est_pkg::OFS_CNT_HIGH: rd_byte = buf_q;
			est_pkg::OFS_IRQ_STAT: rd_byte = {7'h00, stat_q};
			est_pkg::OFS_IRQ_MASK: rd_byte = {7'h00, mask_q};
			default:               rd_byte = 8'h00;
		endcase
	end

	// Read data stands from the accept edge through the completing edge
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Control registers; bit 5 of control A is not stored
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			ctrl_a_q <= est_pkg::CTRL_A_RST;
			ctrl_b_q <= est_pkg::CTRL_B_RST;
		end else if (wr_go) begin
			if (i_avs_address == est_pkg::OFS_CTRL_A) begin
				ctrl_a_q <= i_avs_writedata[7:0] & 8'hDF;
			end
			if (i_avs_address == est_pkg::OFS_CTRL_B) begin
				ctrl_b_q <= i_avs_writedata[7:0] & 8'h3F;
			end
		end
	end

	assign run      = ctrl_a_q[est_pkg::A_ENABLE_BIT];
	assign w16      = ctrl_a_q[est_pkg::A_WIDTH_BIT];  // [RQ1]
	assign is_async = ctrl_b_q[est_pkg::B_ASYNC_BIT];

	// ------------------------------------------------------------
	// Clock sources
	// ------------------------------------------------------------
	// Instruction clock enable at a quarter of the core rate; it stops in
	// sleep like the real instruction clock would
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			div_q <= 2'h0;
		end else if (!i_sleep) begin
			div_q <= (div_q == est_pkg::INST_DIV_LAST) ? 2'h0 : div_q + 2'h1;
		end
	end
	assign inst_tick = ~i_sleep & (div_q == est_pkg::INST_DIV_LAST);  // [RQ12]

	// Pin synchroniser; s1 only feeds s2, a change is taken once s2 and s3 agree
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s1_q        <= 1'b0;
			s2_q        <= 1'b0;
			s3_q        <= 1'b0;
			filt_q      <= 1'b0;
			filt_prev_q <= 1'b0;
		end else begin
			s1_q        <= i_count_in;
			s2_q        <= s1_q;
			s3_q        <= s2_q;
			filt_q      <= (s2_q == s3_q) ? s2_q : filt_q;
			filt_prev_q <= filt_q;
		end
	end
	assign pin_rise = filt_q & ~filt_prev_q;

	// Counter mode takes pin edges, timer mode takes instruction cycles
	assign raw_evt = run & (ctrl_b_q[est_pkg::B_CNTR_BIT] ? pin_rise : inst_tick);  // [RQ2] [RQ10]

	// ------------------------------------------------------------
	// Prescaler, private to this counter
	// ------------------------------------------------------------
	// Ratio is two to the power of the select field; zero bypasses it
	assign pre_mask = 15'((16'h0001 << ctrl_b_q[3:0]) - 16'h0001);
	assign pre_out  = (ctrl_b_q[3:0] == est_pkg::PRE_BYPASS) ? raw_evt :
	                  (raw_evt & ((pre_q & pre_mask) == pre_mask));  // [RQ9] [RQ10]
	assign scl_clr  = wr_low | wr_ctrl;  // [RQ8]

	// No watchdog path touches this divider [RQ15]
	always_ff @(posedge i_core_clk) begin
		if (i_srst || scl_clr) begin
			pre_q <= 15'h0000;  // [RQ8]
		end else if (raw_evt) begin
			pre_q <= pre_q + 15'h0001;  // [RQ2]
		end
	end

	// ------------------------------------------------------------
	// Synchronous alignment
	// ------------------------------------------------------------
	// A prescaled edge waits for the next instruction cycle. Several edges in
	// one instruction cycle merge into one count, so the source must stay
	// below the instruction rate [RQ13]
	always_ff @(posedge i_core_clk) begin
		if (i_srst || scl_clr || is_async) begin
			pend_q <= 1'b0;
		end else if (inst_tick) begin
			pend_q <= 1'b0;
		end else if (pre_out) begin
			pend_q <= 1'b1;
		end
	end

	// Async counts at once and keeps going in sleep in counter mode only; sync waits for a tick
	assign cnt_evt = is_async ? pre_out :
	                 ((pend_q | pre_out) & inst_tick);  // [RQ11] [RQ12]

	// ------------------------------------------------------------
	// Count registers
	// ------------------------------------------------------------
	assign match8 = cnt_evt & ~w16 & (low_q == period_q);  // [RQ5]
	assign wrap16 = cnt_evt & w16 & ({high_true_q, low_q} == 16'hFFFF);  // [RQ17]
	assign evt    = match8 | wrap16;

	// Low byte; a bus write wins over a count in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			low_q <= est_pkg::CNT_LOW_RST;  // [RQ7]
		end else if (wr_low) begin
			low_q <= i_avs_writedata[7:0];
		end else if (match8) begin
			low_q <= 8'h00;  // [RQ5]
		end else if (cnt_evt) begin
			low_q <= low_q + 8'h01;  // [RQ9]
		end
	end

	// Hidden upper byte, used in 16-bit width only
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			high_true_q <= 8'h00;
		end else if (wr_low && w16) begin
			high_true_q <= buf_q;  // [RQ4]
		end else if (cnt_evt && w16 && (low_q == 8'hFF)) begin
			high_true_q <= high_true_q + 8'h01;  // [RQ17]
		end
	end

	// High buffer: direct register in 8-bit width, snapshot in 16-bit width.
	// The copy happens at the read accept, the same edge that latches low.
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			buf_q <= est_pkg::CNT_HIGH_RST;  // [RQ7]
		end else if (wr_high) begin
			buf_q <= i_avs_writedata[7:0];  // [RQ7]
		end else if (rd_go && w16 && (i_avs_address == est_pkg::OFS_CNT_LOW)) begin
			buf_q <= high_true_q;  // [RQ3]
		end
	end

	// Period buffer reloads from the high register on each match
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			period_q <= est_pkg::PERIOD_RST;
		end else if (match8) begin
			period_q <= buf_q;  // [RQ6]
		end
	end

	// ------------------------------------------------------------
	// Match pulse and postscaler
	// ------------------------------------------------------------
	// Pulse holds until the next prescaled count that is not a match
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			out_q <= 1'b0;
		end else if (evt) begin
			out_q <= 1'b1;  // [RQ6]
		end else if (cnt_evt) begin
			out_q <= 1'b0;
		end
	end

	// Both copies follow the pulse one cycle late; or-ing in evt would stretch it
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_match_periph <= 1'b0;
			o_match_pin    <= 1'b0;
		end else begin
			o_match_periph <= out_q;  // [RQ16]
			o_match_pin    <= out_q;  // [RQ16]
		end
	end

	// Postscale ratio is the select field plus one
	assign post_hit = evt & (post_q == ctrl_a_q[3:0]);
	always_ff @(posedge i_core_clk) begin
		if (i_srst || scl_clr) begin
			post_q <= 4'h0;  // [RQ8]
		end else if (post_hit) begin
			post_q <= 4'h0;
		end else if (evt) begin
			post_q <= post_q + 4'h1;  // [RQ14]
		end
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	// Write one to clear; a new event in the same cycle keeps the flag set
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			stat_q <= 1'b0;
			mask_q <= 1'b0;
		end else begin
			stat_q <= post_hit | (stat_q & ~(wr_go &&
			          (i_avs_address == est_pkg::OFS_IRQ_STAT) &&
			          i_avs_writedata[est_pkg::STAT_FLAG]));  // [RQ14]
			if (wr_go && (i_avs_address == est_pkg::OFS_IRQ_MASK)) begin
				mask_q <= i_avs_writedata[est_pkg::STAT_FLAG];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= stat_q & mask_q;
		end
	end

	assign o_irq             = irq_q;
	assign o_avs_readdata    = rdata_q;
	assign o_avs_waitrequest = wait_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	a_eight_match_clear: assert property (match8 && !wr_low |=> low_q == 8'h00)  // [RQ5]
		else $error("low byte not cleared on period match");
	a_period_reload: assert property (match8 && !wr_high |=> period_q == $past(buf_q))  // [RQ6]
		else $error("period buffer not reloaded on match");
	a_match_pulse: assert property (evt |=> out_q ##1 o_match_pin && o_match_periph)  // [RQ6]
		else $error("match pulse missing");
	a_read_snapshot: assert property (rd_go && w16 && i_avs_address == est_pkg::OFS_CNT_LOW
		|=> buf_q == $past(high_true_q))  // [RQ3]
		else $error("high buffer not copied on low read");
	a_write_load: assert property (wr_low && w16 |=> high_true_q == $past(buf_q)
		&& low_q == $past(i_avs_writedata[7:0]))  // [RQ4]
		else $error("16-bit write not applied together");
	a_scaler_clear: assert property (scl_clr |=> pre_q == 15'h0000 && post_q == 4'h0)  // [RQ8]
		else $error("scalers not cleared");
	a_reset_values: assert property (disable iff (1'b0) i_srst |=> low_q == 8'h00
		&& buf_q == 8'hFF && pre_q == 15'h0000)  // [RQ7]
		else $error("wrong values after reset");
	a_count_step: assert property (cnt_evt && !match8 && !wr_low |=> low_q == $past(low_q) + 8'h01)  // [RQ9]
		else $error("count did not advance by one");
	a_sync_align: assert property (cnt_evt && !is_async |-> inst_tick)  // [RQ12]
		else $error("synchronous count off the instruction clock");
	a_sixteen_wrap: assert property (wrap16 && !wr_low |=> low_q == 8'h00 && high_true_q == 8'h00)  // [RQ17]
		else $error("16-bit wrap wrong");
	a_flag_sticky: assert property (post_hit |=> stat_q ##1 (irq_q == $past(mask_q)))  // [RQ14]
		else $error("interrupt flag or line wrong");
endmodule

// ==== bench/est_source_model.sv ====
// Count source model for the timer's count pin.
// Assumes the core clock; the pin idles low between bursts.
module est_source_model (
	// Clock
	input  wire logic i_core_clk,
	// Count pin
	output logic      o_count_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Start low so no edge is seen before the first burst
	initial begin
		o_count_in = 1'b0;
	end

	// Burst of n pulses, each level held h clocks; callers keep h >= 2
	// so edges never come faster than the instruction clock
	task automatic send(input int n, input int h);
		repeat (n) begin
			repeat (h) @(posedge i_core_clk);
			o_count_in <= 1'b1;
			repeat (h) @(posedge i_core_clk);
			o_count_in <= 1'b0;
		end
	endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench: registers, period match, prescale, postscale, irq,
// 16-bit pairing, pin counting and reset. Assumes est_pkg compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------
	// Signals
	// ------------
	logic        clk;
	logic        srst;
	logic [4:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wdat;
	logic [3:0]  be;
	logic [31:0] rdat;
	logic        wreq;
	logic        cnt_in;
	logic        sleep;
	logic        m_per;
	logic        m_pin;
	logic        irq;
	logic [7:0]  v;
	int          bad_count;
	int          n_tests;
	int          cyc;
	int          hi;
	int          per;
	int          t0;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] d;
		logic [3:0] b;
		logic [7:0] e;
	} est_row_t;
	typedef struct packed {
		logic [7:0] b;
		logic       s;
		logic [7:0] n;
		logic [7:0] h;
		logic [7:0] e;
	} est_crow_t;
	// Write, readback: unused bits, read-only bit, byte lane off, unmapped
	est_row_t    rows [9] = '{
		'{est_pkg::OFS_CNT_HIGH, 8'h5A, 4'hF, 8'h5A},
		'{est_pkg::OFS_CNT_LOW, 8'h3C, 4'hF, 8'h3C},
		'{est_pkg::OFS_CNT_LOW, 8'h77, 4'hE, 8'h3C},
		'{est_pkg::OFS_IRQ_MASK, 8'hFF, 4'hF, 8'h01},
		'{est_pkg::OFS_CTRL_B, 8'hFF, 4'hF, 8'h3F},
		'{est_pkg::OFS_CTRL_B, 8'h00, 4'hF, 8'h00},
		'{est_pkg::OFS_CTRL_A, 8'h7F, 4'hF, 8'h5F},
		'{est_pkg::OFS_CTRL_A, 8'h00, 4'hF, 8'h00},
		'{5'h18, 8'hAA, 4'hF, 8'h00}};
	// Pin counting: control B, sleep, pulses, hold, expected low byte
	est_crow_t   crows [4] = '{
		'{8'h20, 1'b0, 8'd10, 8'd4, 8'h0A},
		'{8'h21, 1'b0, 8'd8, 8'd9, 8'h04},
		'{8'h30, 1'b1, 8'd7, 8'd4, 8'h07},
		'{8'h33, 1'b1, 8'd16, 8'd5, 8'h02}};
	logic [4:0]  rst_a [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
	logic [7:0]  rst_e [6] = '{est_pkg::CTRL_A_RST, est_pkg::CTRL_B_RST,
		est_pkg::CNT_LOW_RST, est_pkg::CNT_HIGH_RST, 8'h00, 8'h00};

	est_timer i_est_timer (
		.i_core_clk        (clk),
		.i_srst            (srst),
		.i_avs_address     (adr),
		.i_avs_read        (rd),
		.i_avs_write       (wr),
		.i_avs_writedata   (wdat),
		.i_avs_byteenable  (be),
		.o_avs_readdata    (rdat),
		.o_avs_waitrequest (wreq),
		.i_count_in        (cnt_in),
		.i_sleep           (sleep),
		.o_match_periph    (m_per),
		.o_match_pin       (m_pin),
		.o_irq             (irq)
	);
	est_source_model i_est_source_model (
		.i_core_clk (clk),
		.o_count_in (cnt_in)
	);

	// 25 ns core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Cycle count doubles as time base and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			complete_run();
		end
	end
	// ------------
	// Tasks
	// ------------
	task automatic complete_run();
		if (bad_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_n(input string nm, input int e, input int g);
		n_tests++;
		if (g != e) begin
			bad_count++;
			$display("BAD %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// Request held until the edge that samples waitrequest low
	task automatic bus_wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] b = 4'hF);
		@(posedge clk);
		adr <= a;
		wdat <= {24'h000000, d};
		be <= b;
		wr <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		d = rdat[7:0];
		rd <= 1'b0;
	endtask
	function automatic logic pick(input int sel);
		return (sel == 0) ? m_per : (sel == 1) ? m_pin : irq;
	endfunction
	task automatic wait_lvl(input int sel, input logic lvl);
		int i;
		for (i = 0; i < 4000 && pick(sel) !== lvl; i++) @(posedge clk);
		if (i == 4000) chk_n("wait level", 0, 1);
	endtask
	// High time and rise-to-rise time of one output, from a fresh rise
	task automatic measure(input int sel);
		wait_lvl(sel, 1'b0);
		wait_lvl(sel, 1'b1);
		hi = 0;
		per = 0;
		while (pick(sel) === 1'b1 && per < 4000) begin
			@(posedge clk);
			hi++;
			per++;
		end
		while (pick(sel) !== 1'b1 && per < 4000) begin
			@(posedge clk);
			per++;
		end
	endtask
	task automatic check_reset();
		for (int k = 0; k < 6; k++) begin
			bus_rd(rst_a[k], v);
			chk8("reset value", rst_e[k], v);
		end
		chk8("reset irq", 8'h00, {7'h00, irq});
	endtask
	// ------------
	// Main sequence
	// ------------
	initial begin
		srst = 1'b1;
		adr = 5'h00;
		rd = 1'b0;
		wr = 1'b0;
		wdat = 32'h00000000;
		be = 4'h0;
		sleep = 1'b0;
		bad_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		check_reset();
		foreach (rows[k]) begin
			bus_wr(rows[k].a, rows[k].d, rows[k].b);
			bus_rd(rows[k].a, v);
			chk8("readback", rows[k].e, v);
			chk8("readdata upper", 8'h00, {7'h00, |rdat[31:8]});
		end
		// 8-bit period 5: first match at FF reloads the period buffer
		bus_wr(est_pkg::OFS_CNT_HIGH, 8'h05);
		bus_wr(est_pkg::OFS_CNT_LOW, 8'hFF);
		bus_wr(est_pkg::OFS_IRQ_MASK, 8'h01);
		bus_wr(est_pkg::OFS_CTRL_A, 8'h80);
		for (int p = 0; p < 3; p++) begin
			bus_wr(est_pkg::OFS_CTRL_B, 8'(p));
			measure(0);
			chk_n("match width", 4 << p, hi);
			chk_n("match period", 24 << p, per);
			measure(1);
			chk_n("pin width", 4 << p, hi);
		end
		bus_wr(est_pkg::OFS_CTRL_B, 8'h00);
		for (int q = 0; q < 3; q++) begin
			bus_wr(est_pkg::OFS_CTRL_A, 8'h80 | 8'(q));
			// Clear just after a match so no new event lands on the clear
			wait_lvl(0, 1'b0);
			wait_lvl(0, 1'b1);
			bus_wr(est_pkg::OFS_IRQ_STAT, 8'h01);
			wait_lvl(2, 1'b0);
			wait_lvl(2, 1'b1);
			t0 = cyc;
			bus_wr(est_pkg::OFS_IRQ_STAT, 8'h01);
			wait_lvl(2, 1'b0);
			wait_lvl(2, 1'b1);
			chk_n("irq spacing", 24 * (q + 1), cyc - t0);
		end
		// Masking holds irq low while the sticky status stays set
		bus_wr(est_pkg::OFS_IRQ_MASK, 8'h00);
		repeat (60) @(posedge clk);
		bus_rd(est_pkg::OFS_IRQ_STAT, v);
		chk8("status sticky", 8'h01, v);
		chk8("masked irq", 8'h00, {7'h00, irq});
		bus_wr(est_pkg::OFS_CTRL_A, 8'h00);
		bus_wr(est_pkg::OFS_IRQ_STAT, 8'h01);
		bus_rd(est_pkg::OFS_IRQ_STAT, v);
		chk8("status cleared", 8'h00, v);
		bus_wr(est_pkg::OFS_IRQ_MASK, 8'h01);
		// 16-bit pairing: a stray buffer write is overwritten by the snapshot
		bus_wr(est_pkg::OFS_CTRL_A, 8'h10);
		bus_wr(est_pkg::OFS_CNT_HIGH, 8'h12);
		bus_wr(est_pkg::OFS_CNT_LOW, 8'h34);
		bus_wr(est_pkg::OFS_CNT_HIGH, 8'h77);
		bus_rd(est_pkg::OFS_CNT_LOW, v);
		chk8("low 16-bit", 8'h34, v);
		bus_rd(est_pkg::OFS_CNT_HIGH, v);
		chk8("high snapshot", 8'h12, v);
		bus_wr(est_pkg::OFS_CNT_HIGH, 8'hFF);
		bus_wr(est_pkg::OFS_CNT_LOW, 8'hFC);
		bus_wr(est_pkg::OFS_CTRL_A, 8'h90);
		wait_lvl(0, 1'b0);
		wait_lvl(0, 1'b1);
		bus_wr(est_pkg::OFS_CTRL_A, 8'h10);
		bus_rd(est_pkg::OFS_CNT_LOW, v);
		bus_rd(est_pkg::OFS_CNT_HIGH, v);
		chk8("high after wrap", 8'h00, v);
		chk8("overflow irq", 8'h01, {7'h00, irq});
		// Reset in mid-run restores every register
		bus_wr(est_pkg::OFS_CTRL_A, 8'h90);
		repeat (10) @(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		check_reset();
		foreach (crows[k]) begin
			bus_wr(est_pkg::OFS_CTRL_A, 8'h00);
			bus_wr(est_pkg::OFS_CTRL_B, crows[k].b);
			bus_wr(est_pkg::OFS_CNT_LOW, 8'h00);
			bus_wr(est_pkg::OFS_CTRL_A, 8'h80);
			sleep <= crows[k].s;
			i_est_source_model.send(crows[k].n, crows[k].h);
			repeat (16) @(posedge clk);
			sleep <= 1'b0;
			bus_rd(est_pkg::OFS_CNT_LOW, v);
			chk8("pin count", crows[k].e, v);
		end
		// Low-byte write drops a partly filled prescaler
		bus_wr(est_pkg::OFS_CTRL_B, 8'h22);
		bus_wr(est_pkg::OFS_CNT_LOW, 8'h00);
		i_est_source_model.send(3, 6);
		repeat (16) @(posedge clk);
		bus_wr(est_pkg::OFS_CNT_LOW, 8'h00);
		i_est_source_model.send(1, 6);
		repeat (16) @(posedge clk);
		bus_rd(est_pkg::OFS_CNT_LOW, v);
		chk8("prescaler cleared", 8'h00, v);
		i_est_source_model.send(3, 6);
		repeat (16) @(posedge clk);
		bus_rd(est_pkg::OFS_CNT_LOW, v);
		chk8("prescaler restart", 8'h01, v);
		// Timer mode halts in sleep and resumes after
		bus_wr(est_pkg::OFS_CTRL_B, 8'h00);
		sleep <= 1'b1;
		bus_wr(est_pkg::OFS_CNT_LOW, 8'h00);
		repeat (40) @(posedge clk);
		bus_rd(est_pkg::OFS_CNT_LOW, v);
		chk8("timer in sleep", 8'h00, v);
		sleep <= 1'b0;
		repeat (40) @(posedge clk);
		bus_rd(est_pkg::OFS_CNT_LOW, v);
		chk_n("timer resumes", 1, int'(v >= 8'h0A && v <= 8'h0C));
		complete_run();
	end
endmodule
